// ---- design/trf_formatter.sv ----
// Purpose: turns touch points into eight-byte input reports, three layouts
// Assumes: point source and report sink share hclk; AHB-Lite register access
// Notes: coordinates arrive as 12-bit values with lower-left origin
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "trf_defs.svh"

// Function
// - first byte of every report is its identifier, naming the layout.
// - identifiers 1 compatible, 2 packed for drivers, 7 packed for utilities.
// - compatible layout is active after reset, sent whenever a new point arrives.
// - compatible layout sends at most 125 points per second.
// - compatible coordinates use upper-left origin.
// - compatible byte 0 is 0x01, byte 1 is 0x01 touched else 0x00.
// - compatible 10-bit X in bytes 2/3, 10-bit Y in bytes 4/5, low first.
// - packed report carries two points, identifier 0x02 or 0x07.
// - packed byte 1 status1 low nibble, X1 low nibble high; byte 2 X1[11:4].
// - packed byte 3 Y1[7:0]; byte 4 Y1[11:8] low, status2 high.
// - packed byte 5 X2[7:0]; byte 6 X2[11:8], Y2[3:0]; byte 7 Y2[11:4].
// - status nibble bit 0 touched, bit 1 valid, bits 2 and 3 zero.
// - first packed point always valid, only second may be invalid.
// - reports go out only on sensor events; register reads answer requests.
// - device reports USB revision 1.1.
// - fixed vendor and product codes readable for host drivers.
// - one layout active at a time; a new selection replaces the old.
// - codes 0 off, 1 on, 2 compatible, 3 packed, 6 utility, 7 restore.
module trf_formatter
    import trf_pkg::*;
#(
    parameter int COMPAT_GAP_CYC = `TRF_CLK_HZ / `TRF_COMPAT_PTS_PER_S
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pt_valid,
    output logic pt_ready,
    input wire logic [11:0] pt1_x,
    input wire logic [11:0] pt1_y,
    input wire logic pt1_touch,
    input wire logic pt2_valid,
    input wire logic [11:0] pt2_x,
    input wire logic [11:0] pt2_y,
    input wire logic pt2_touch,
    output logic rpt_valid,
    input wire logic rpt_ready,
    output logic [7:0] rpt_data,
    output logic rpt_last,
    output logic rpt_tool_pipe
);
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        addr_is = (a[11:2] == ofs[11:2]);
    endfunction

    // status nibble: bit0 touched, bit1 valid, upper bits unused
    function automatic logic [3:0] status_nib(input logic valid, input logic touch);
        status_nib = {2'b00, valid, touch & valid};
    endfunction

    trf_state_e state_q;
    trf_state_e state_d;
    trf_layout_e layout_q;
    trf_layout_e prev_layout_q;
    trf_layout_e rpt_layout_q;
    logic enabled_q;
    logic [2:0] sel_code_q;
    logic [2:0] idx_q;
    logic [2:0] idx_d;
    logic [19:0] gap_q;
    logic [15:0] rpt_cnt_q;
    logic [63:0] rpt_bytes;
    logic [9:0] cx10;
    logic [9:0] cy10;
    logic take_pt;
    logic gap_ok;
    logic rpt_done;
    logic [7:0] rd_byte;

    logic ap_q;
    logic ap_write_q;
    logic [11:0] ap_addr_q;
    logic ap_take;
    logic sel_wr;
    logic [31:0] rd_mux;

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_take = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 12'h000;
        end else if (hready) begin
            ap_q <= ap_take;
            ap_write_q <= hwrite;
            ap_addr_q <= haddr;
        end
    end

    // read data are chosen in the address phase so they leave a flip-flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_is(haddr, `TRF_OFS_SEL)) begin
            rd_mux = {29'h0, sel_code_q};
        end else if (addr_is(haddr, `TRF_OFS_STAT)) begin
            rd_mux = {rpt_cnt_q, 9'h000, ~gap_ok, (state_q != TRF_ST_IDLE), enabled_q,
                      2'b00, layout_q};
        end else if (addr_is(haddr, `TRF_OFS_IDENT)) begin
            rd_mux = {`TRF_PRODUCT_CODE, `TRF_VENDOR_CODE};
        end else if (addr_is(haddr, `TRF_OFS_USBREV)) begin
            rd_mux = {16'h0000, `TRF_USB_REV_BCD};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    assign sel_wr = ap_q & ap_write_q & addr_is(ap_addr_q, `TRF_OFS_SEL);

    // layout selection; unknown codes are stored but change nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_code_q <= `TRF_SEL_RESET;
            enabled_q <= 1'b1;
            layout_q <= TRF_LAY_COMPAT;
            prev_layout_q <= TRF_LAY_COMPAT;
        end else if (sel_wr) begin
            sel_code_q <= hwdata[2:0];
            case (hwdata[2:0])
                `TRF_CODE_OFF: begin
                    enabled_q <= 1'b0;
                end
                `TRF_CODE_ON: begin
                    enabled_q <= 1'b1;
                end
                `TRF_CODE_COMPAT: begin
                    layout_q <= TRF_LAY_COMPAT;
                    prev_layout_q <= TRF_LAY_COMPAT;
                end
                `TRF_CODE_PACKED: begin
                    layout_q <= TRF_LAY_PACKED;
                    prev_layout_q <= TRF_LAY_PACKED;
                end
                `TRF_CODE_TOOL: begin
                    layout_q <= TRF_LAY_TOOL;
                end
                `TRF_CODE_RESTORE: begin
                    layout_q <= prev_layout_q;
                end
                default: begin
                    layout_q <= layout_q;
                end
            endcase
        end
    end

    // compatible-layout pacing: source is stalled rather than points dropped
    assign gap_ok = (gap_q == 20'h00000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 20'h00000;
        end else if (take_pt && layout_q == TRF_LAY_COMPAT) begin
            gap_q <= 20'(COMPAT_GAP_CYC - 1);
        end else if (!gap_ok) begin
            gap_q <= gap_q - 20'h00001;
        end
    end

    // while reports are off the source is drained and its points discarded
    assign pt_ready = (state_q == TRF_ST_IDLE) &&
                      (!enabled_q || layout_q != TRF_LAY_COMPAT || gap_ok);
    assign take_pt = pt_valid & pt_ready & enabled_q;

    // flip Y for the upper-left origin, drop the two low bits for 10-bit range
    assign cx10 = pt1_x[11:2];
    assign cy10 = `TRF_COORD10_MAX - pt1_y[11:2];

    always_comb begin
        rpt_bytes = 64'h0;
        if (layout_q == TRF_LAY_COMPAT) begin
            rpt_bytes[7:0] = `TRF_COMPAT_REPORT_CODE;
            rpt_bytes[15:8] = pt1_touch ? `TRF_TOUCHED_BYTE : `TRF_UNTOUCHED_BYTE;
            rpt_bytes[23:16] = cx10[7:0];
            rpt_bytes[31:24] = {6'h00, cx10[9:8]};
            rpt_bytes[39:32] = cy10[7:0];
            rpt_bytes[47:40] = {6'h00, cy10[9:8]};
            rpt_bytes[63:48] = 16'h0000;
        end else begin
            if (layout_q == TRF_LAY_TOOL) begin
                rpt_bytes[7:0] = `TRF_PACKED_TOOL_REPORT_CODE;
            end else begin
                rpt_bytes[7:0] = `TRF_PACKED_DRIVER_REPORT_CODE;
            end
            rpt_bytes[15:8] = {pt1_x[3:0], status_nib(1'b1, pt1_touch)};
            rpt_bytes[23:16] = pt1_x[11:4];
            rpt_bytes[31:24] = pt1_y[7:0];
            rpt_bytes[39:32] = {status_nib(pt2_valid, pt2_touch), pt1_y[11:8]};
            rpt_bytes[47:40] = pt2_x[7:0];
            rpt_bytes[55:48] = {pt2_y[3:0], pt2_x[11:8]};
            rpt_bytes[63:56] = pt2_y[11:4];
        end
    end

    // report sequencer: capture, one cycle to fetch byte 0, then stream
    assign rpt_done = (state_q == TRF_ST_SEND) && rpt_ready && (idx_q == `TRF_IDX_LAST);

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            TRF_ST_IDLE: begin
                idx_d = 3'h0;
                if (take_pt) begin
                    state_d = TRF_ST_LOAD;
                end
            end
            TRF_ST_LOAD: begin
                idx_d = 3'h0;
                state_d = TRF_ST_SEND;
            end
            TRF_ST_SEND: begin
                if (rpt_ready) begin
                    if (idx_q == `TRF_IDX_LAST) begin
                        state_d = TRF_ST_IDLE;
                        idx_d = 3'h0;
                    end else begin
                        idx_d = idx_q + 3'h1;
                    end
                end
            end
            default: begin
                state_d = TRF_ST_IDLE;
                idx_d = 3'h0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= TRF_ST_IDLE;
            idx_q <= 3'h0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    // a layout change mid-report does not disturb the report in flight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rpt_layout_q <= TRF_LAY_COMPAT;
        end else if (take_pt) begin
            rpt_layout_q <= layout_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rpt_cnt_q <= 16'h0000;
        end else if (rpt_done) begin
            rpt_cnt_q <= rpt_cnt_q + 16'h0001;
        end
    end

    trf_report_buf u_buf (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(take_pt),
        .wr_data(rpt_bytes),
        .rd_addr(idx_d),
        .rd_data(rd_byte)
    );

    assign rpt_valid = (state_q == TRF_ST_SEND);
    assign rpt_data = rd_byte;
    assign rpt_last = (state_q == TRF_ST_SEND) && (idx_q == `TRF_IDX_LAST);
    // utility reports leave on the control pipe, the others on the interrupt pipe
    assign rpt_tool_pipe = (rpt_layout_q == TRF_LAY_TOOL);
endmodule

// ---- design/trf_report_buf.sv ----
// Purpose: eight-byte report store with registered read port
// Assumes: whole report written in one cycle
// Notes: read data appear one edge after rd_addr
`timescale 1ns/10ps
module trf_report_buf (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [63:0] wr_data,
    input wire logic [2:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [0:7];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_byte
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mem_q[gi] <= 8'h00;
                end else if (wr_en) begin
                    mem_q[gi] <= wr_data[gi*8 +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

// ---- pkg/trf_defs.svh ----
// Purpose: constants of the touch report formatter
// Assumes: 100 MHz system clock, AHB-Lite register window of four words
// Notes: offsets are byte addresses
`ifndef TRF_DEFS_SVH
`define TRF_DEFS_SVH

`define TRF_CLK_HZ 100000000
`define TRF_COMPAT_PTS_PER_S 125
`define TRF_RPT_BYTES 8
`define TRF_IDX_LAST 3'h7

`define TRF_OFS_SEL 12'h000
`define TRF_OFS_STAT 12'h004
`define TRF_OFS_IDENT 12'h008
`define TRF_OFS_USBREV 12'h00c

`define TRF_CODE_OFF 3'h0
`define TRF_CODE_ON 3'h1
`define TRF_CODE_COMPAT 3'h2
`define TRF_CODE_PACKED 3'h3
`define TRF_CODE_TOOL 3'h6
`define TRF_CODE_RESTORE 3'h7

`define TRF_COMPAT_REPORT_CODE 8'h01
`define TRF_PACKED_DRIVER_REPORT_CODE 8'h02
`define TRF_PACKED_TOOL_REPORT_CODE 8'h07
`define TRF_TOUCHED_BYTE 8'h01
`define TRF_UNTOUCHED_BYTE 8'h00
`define TRF_COORD10_MAX 10'h3ff

`define TRF_USB_REV_BCD 16'h0110
`define TRF_VENDOR_CODE 16'h1234
`define TRF_PRODUCT_CODE 16'h5678

`define TRF_SEL_RESET 3'h2

`endif

// ---- pkg/trf_pkg.sv ----
// Purpose: types of the touch report formatter
// Assumes: constants live in trf_defs.svh
// Notes: none
package trf_pkg;
    typedef enum logic [1:0] {
        TRF_LAY_COMPAT = 2'b00,
        TRF_LAY_PACKED = 2'b01,
        TRF_LAY_TOOL = 2'b10
    } trf_layout_e;

    typedef enum logic [1:0] {
        TRF_ST_IDLE = 2'b00,
        TRF_ST_LOAD = 2'b01,
        TRF_ST_SEND = 2'b10
    } trf_state_e;
endpackage

// ---- tb/touch_report_formatter_test.sv ----
// Purpose: self-checking bench of the touch report formatter
// Assumes: pacing shortened to GAP cycles
// Notes: expected reports come from a small layout model
`timescale 1ns/10ps
`include "trf_defs.svh"
`define CHK(n, e, s) begin \
    num_checks++; \
    if ((s) !== (e)) begin \
        err_count++; \
        $display("FAIL %s exp %h got %h", n, e, s); \
    end \
end
module touch_report_formatter_test;
    localparam int GAP = 20;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
    logic pt_valid = 0, pt1_touch = 0, pt2_valid = 0, pt2_touch = 0;
    logic [11:0] haddr = '0, pt1_x = '0, pt1_y = '0, pt2_x = '0, pt2_y = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0, hrdata, rd;
    logic hreadyout, hresp, pt_ready, rpt_valid, rpt_ready, rpt_last, rpt_tool_pipe;
    logic [7:0] rpt_data;
    logic [63:0] rpt;
    int n_rpt, err_count = 0, num_checks = 0, seed = 8, lay = 0, prv = 0, en = 1;
    int codes[9] = '{3, 6, 7, 4, 2, 6, 7, 0, 1};
    always #5 hclk = ~hclk;
    trf_formatter #(.COMPAT_GAP_CYC(GAP)) DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pt_valid, .pt_ready,
        .pt1_x, .pt1_y, .pt1_touch, .pt2_valid, .pt2_x, .pt2_y, .pt2_touch,
        .rpt_valid, .rpt_ready, .rpt_data, .rpt_last, .rpt_tool_pipe);
    trf_host_model host (.hclk, .hresetn, .slow, .rpt_valid, .rpt_data, .rpt_last,
        .rpt_ready, .rpt, .n_rpt);
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // looks at the handshake at the falling edge so the take edge is never raced
    task automatic wait_hi(input bit pt);
        int t;
        t = 0;
        @(negedge hclk);
        while ((pt ? pt_ready : hreadyout) !== 1'b1 && t < 300) begin
            @(negedge hclk);
            t++;
        end
        // a handshake that never comes is a failure, not a silent skip
        if (t >= 300) err_count++;
        @(posedge hclk);
    endtask
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_hi(0);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_hi(0);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    function automatic logic [63:0] exp_rpt(input logic [63:0] r);
        logic [9:0] x, y;
        logic [3:0] s1, s2;
        x = r[11:2];
        y = 10'h3ff - r[23:14];
        s1 = {3'b001, r[24]};
        s2 = {2'b00, r[25], r[25] & r[50]};
        if (lay == 0)
            return {22'h0, y, 6'h0, x[9:8], x[7:0], 7'h0, r[24], 8'h01};
        return {r[49:26], s2, r[23:4], r[3:0], s1, (lay == 2) ? 8'h07 : 8'h02};
    endfunction
    task automatic sel(input int c);
        ahb(12'h000, 1'b1, c);
        case (c)
            0: en = 0;
            1: en = 1;
            2: begin lay = 0; prv = 0; end
            3: begin lay = 1; prv = 1; end
            6: lay = 2;
            7: lay = prv;
            default: ;
        endcase
        ahb(12'h000, 1'b0, 32'h0);
        `CHK("sel", c, rd)
        ahb(12'h004, 1'b0, 32'h0);
        `CHK("stat", {1'b0, en[0], 2'b00, lay[1:0]}, rd[5:0])
        `CHK("count", n_rpt, rd[31:16])
    endtask
    task automatic send(input logic [63:0] r);
        logic [63:0] e;
        int n0, t;
        e = exp_rpt(r);
        n0 = n_rpt;
        {pt2_touch, pt2_y, pt2_x, pt2_valid, pt1_touch, pt1_y, pt1_x} <= r[50:0];
        pt_valid <= 1'b1;
        wait_hi(1);
        pt_valid <= 1'b0;
        if (en) begin
            t = 0;
            while (n_rpt == n0 && t < 300) begin
                @(posedge hclk);
                t++;
            end
            `CHK("reports", n0 + 1, n_rpt)
            `CHK("report", e, rpt)
        end else begin
            repeat (40) @(posedge hclk);
            `CHK("dropped", n0, n_rpt)
        end
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(12'h000, 1'b0, 32'h0);
        `CHK("sel reset", 32'h2, rd)
        ahb(12'h008, 1'b0, 32'h0);
        `CHK("ident", {`TRF_PRODUCT_CODE, `TRF_VENDOR_CODE}, rd)
        ahb(12'h00c, 1'b0, 32'h0);
        `CHK("usb rev", 32'h0110, rd)
        ahb(12'h010, 1'b1, 32'hffffffff);
        ahb(12'h010, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        send('1);
        repeat (3) send({$random(seed), $random(seed)});
        foreach (codes[k]) begin
            slow <= k[0];
            sel(codes[k]);
            repeat (2) send({$random(seed), $random(seed)});
        end
        stop_test();
    end
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
endmodule

// ---- tb/trf_checker.sv ----
// Purpose: port-level checks of the report formatter
// Assumes: reports are eight bytes, byte 0 is the identifier
// Notes: byte index is counted from accepted bytes only
`timescale 1ns/10ps
module trf_checker #(
    parameter int COMPAT_GAP_CYC = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pt_valid,
    input wire logic pt_ready,
    input wire logic rpt_valid,
    input wire logic rpt_ready,
    input wire logic [7:0] rpt_data,
    input wire logic rpt_last,
    input wire logic rpt_tool_pipe
);
    logic [2:0] idx_q;
    logic [7:0] id_q;
    logic v_q;
    int cnt_q;
    wire take = pt_valid && pt_ready;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= 3'h0;
            id_q <= 8'h00;
            v_q <= 1'b0;
        end else begin
            v_q <= rpt_valid;
            if (rpt_valid && rpt_ready) begin
                idx_q <= idx_q + 3'h1;
                if (idx_q == 3'h0)
                    id_q <= rpt_data;
            end
        end
    end
    // pacing is judged from report starts, so sink stalls cannot hide a fast source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cnt_q <= COMPAT_GAP_CYC;
        else if (rpt_valid && !v_q && rpt_data == 8'h01)
            cnt_q <= 0;
        else if (cnt_q < COMPAT_GAP_CYC)
            cnt_q <= cnt_q + 1;
    end
    property p_id; rpt_valid && idx_q == 3'h0 |-> rpt_data inside {8'h01, 8'h02, 8'h07}; endproperty
    a_id: assert property (p_id) else $error("bad report id");
    property p_tool; rpt_valid && idx_q == 3'h0 |-> (rpt_data == 8'h07) == rpt_tool_pipe; endproperty
    a_tool: assert property (p_tool) else $error("tool pipe flag wrong");
    property p_last; rpt_valid |-> rpt_last == (idx_q == 3'h7); endproperty
    a_last: assert property (p_last) else $error("last flag off");
    property p_gap; rpt_valid && rpt_ready && rpt_last |=> !rpt_valid; endproperty
    a_gap: assert property (p_gap) else $error("no idle after report");
    property p_event; $rose(rpt_valid) |-> $past(take, 2); endproperty
    a_event: assert property (p_event) else $error("report without point");
    property p_pace; rpt_valid && !v_q && rpt_data == 8'h01 |-> cnt_q >= COMPAT_GAP_CYC - 1; endproperty
    a_pace: assert property (p_pace) else $error("compat rate too high");
    property p_st1; rpt_valid && idx_q == 3'h1 && id_q != 8'h01 |-> rpt_data[3:1] == 3'b001; endproperty
    a_st1: assert property (p_st1) else $error("first status bad");
    property p_st2;
        rpt_valid && idx_q == 3'h4 && id_q != 8'h01 |-> !rpt_data[7:6] && (!rpt_data[4] || rpt_data[5]);
    endproperty
    a_st2: assert property (p_st2) else $error("second status bad");
    property p_cst; rpt_valid && idx_q == 3'h1 && id_q == 8'h01 |-> rpt_data[7:1] == 7'h00; endproperty
    a_cst: assert property (p_cst) else $error("compat status bad");
    property p_chi; rpt_valid && id_q == 8'h01 && idx_q inside {3, 5} |-> rpt_data[7:2] == 6'h00; endproperty
    a_chi: assert property (p_chi) else $error("compat high bits set");
    property p_cpad; rpt_valid && id_q == 8'h01 && idx_q >= 3'h6 |-> rpt_data == 8'h00; endproperty
    a_cpad: assert property (p_cpad) else $error("compat pad not zero");
endmodule
bind trf_formatter trf_checker #(.COMPAT_GAP_CYC(COMPAT_GAP_CYC)) u_chk (.hclk(hclk),
    .hresetn(hresetn), .pt_valid(pt_valid), .pt_ready(pt_ready), .rpt_valid(rpt_valid),
    .rpt_ready(rpt_ready), .rpt_data(rpt_data), .rpt_last(rpt_last),
    .rpt_tool_pipe(rpt_tool_pipe));

// ---- tb/trf_host_model.sv ----
// Purpose: host side sink that gathers eight-byte input reports
// Assumes: ready toggles at random while slow is high
// Notes: byte 0 lands in bits 7:0 of rpt
`timescale 1ns/10ps
module trf_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic rpt_valid,
    input wire logic [7:0] rpt_data,
    input wire logic rpt_last,
    output logic rpt_ready,
    output logic [63:0] rpt,
    output int n_rpt
);
    logic [63:0] part_q;
    logic [2:0] i_q;
    int seed = 8;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rpt_ready <= 1'b0;
            i_q <= 3'h0;
            n_rpt <= 0;
            rpt <= '0;
            part_q <= '0;
        end else begin
            // a host polls at its own pace, so stalls may fall on any byte
            rpt_ready <= slow ? 1'($random(seed)) : 1'b1;
            if (rpt_valid && rpt_ready) begin
                i_q <= rpt_last ? 3'h0 : i_q + 3'h1;
                part_q[8*i_q+:8] <= rpt_data;
                if (rpt_last) begin
                    rpt <= {rpt_data, part_q[55:0]};
                    n_rpt <= n_rpt + 1;
                end
            end
        end
    end
endmodule
